// *** spdr_pkg.sv ***
// package: register map, field positions and constants of the sweep/pll config block
package spdr_pkg;
   // register indices; byte address is four times the index
   localparam logic [7:0] IDX_CTRL_ONE   = 8'h00;
   localparam logic [7:0] IDX_CTRL_TWO   = 8'h01;
   localparam logic [7:0] IDX_PLL_CTRL   = 8'h02;
   localparam logic [7:0] IDX_CTRL_FOUR  = 8'h03;
   localparam logic [7:0] IDX_SWP_LOW    = 8'h04;
   localparam logic [7:0] IDX_SWP_HIGH   = 8'h05;
   localparam logic [7:0] IDX_SWP_RSTEP  = 8'h06;
   localparam logic [7:0] IDX_SWP_FSTEP  = 8'h07;
   localparam logic [7:0] IDX_SWP_RATE   = 8'h08;
   localparam logic [7:0] IDX_IRQ_STAT   = 8'h20;
   localparam logic [7:0] IDX_IRQ_MASK   = 8'h21;
   localparam logic [7:0] IDX_SWP_VALUE  = 8'h22;

   // field positions
   localparam int CP_CUR_HI      = 5;
   localparam int CP_CUR_LO      = 3;
   localparam int LOCK_DET_EN    = 2;
   localparam int LOCK_WIN_HI    = 1;
   localparam int LOCK_WIN_LO    = 0;
   localparam int PLL_LOCK_BIT   = 24;
   localparam int SYNC_PD_BIT    = 26;
   localparam int CAL_CLK_PD_BIT = 25;
   localparam int CAL_START_BIT  = 24;
   localparam int SWP_EN_BIT     = 19;
   localparam int RATE_DN_HI     = 31;
   localparam int RATE_DN_LO     = 16;
   localparam int RATE_UP_HI     = 15;
   localparam int RATE_UP_LO     = 0;

   // interrupt status bits
   localparam int IRQ_LOCK_BIT   = 0;
   localparam int IRQ_UNLOCK_BIT = 1;
   localparam int IRQ_CAL_BIT    = 2;
   localparam int IRQ_HIGH_BIT   = 3;
   localparam int IRQ_LOW_BIT    = 4;
   localparam int IRQ_W          = 5;

   // reset values (defaults of the reserved part kept as a parameter-like constant)
   localparam logic [31:0] CTRL_FOUR_RST = 32'h0000_0000;
   localparam logic [31:0] ZERO_WORD     = 32'h0000_0000;
   localparam logic [31:0] ADDR_ERR_DATA = 32'h0000_0000;

   // lock window lengths in reference clock cycles
   localparam logic [10:0] LOCK_WIN_128  = 11'h080;
   localparam logic [10:0] LOCK_WIN_256  = 11'h100;
   localparam logic [10:0] LOCK_WIN_512  = 11'h200;
   localparam logic [10:0] LOCK_WIN_1024 = 11'h400;

   // converter calibration length in system clock cycles
   localparam logic [7:0] CAL_CYCLES     = 8'h40;

   typedef enum logic [2:0] {
      SWP_IDLE = 3'b001,
      SWP_UP   = 3'b010,
      SWP_DOWN = 3'b100
   } spdr_swp_e;
endpackage

// *** spdr_top.sv ***
// module: pll tail, fourth control word and sweep-generator parameter registers on apb
`timescale 1ns/1ns
`default_nettype none
module spdr_top (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   input  wire logic [3:0]  pstrb,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        ref_clk_tick,
   input  wire logic        phase_err_in_window,
   input  wire logic        sweep_dir_up,
   output logic      [2:0]  charge_pump_current,
   output logic             sync_out_enable,
   output logic             cal_clk_enable,
   output logic             cal_busy,
   output logic      [31:0] sweep_value,
   output logic             sweep_active,
   output logic             irq
);
   //------------------------------------------------------------
   // state
   //------------------------------------------------------------
   typedef struct packed {
      logic [31:0]                 ctrl_one;
      logic [31:0]                 ctrl_two;
      logic [31:0]                 pll_ctrl;
      logic [31:0]                 ctrl_four;
      logic [31:0]                 swp_low;
      logic [31:0]                 swp_high;
      logic [31:0]                 swp_rstep;
      logic [31:0]                 swp_fstep;
      logic [31:0]                 swp_rate;
      logic [spdr_pkg::IRQ_W-1:0]  irq_stat;
      logic [spdr_pkg::IRQ_W-1:0]  irq_mask;
      logic [10:0]                 lock_cnt;
      logic                        locked;
      logic [7:0]                  cal_cnt;
      logic                        cal_busy;
      logic [15:0]                 rate_cnt;
      logic [31:0]                 value;
      spdr_pkg::spdr_swp_e         swp_state;
      logic [31:0]                 prdata;
      logic                        pready;
      logic                        pslverr;
      logic [2:0]                  cp_cur;
      logic                        sync_en;
      logic                        cal_clk_en;
      logic                        irq;
      logic                        swp_act;
   } spdr_state_s;

   spdr_state_s st_q;
   spdr_state_s st_d;

   //------------------------------------------------------------
   // helpers
   //------------------------------------------------------------
   function automatic logic [31:0] merge_bytes(input logic [31:0] old_v,
                                               input logic [31:0] new_v,
                                               input logic [3:0]  strb);
      logic [31:0] r;
      r = old_v;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            r[i*8 +: 8] = new_v[i*8 +: 8];
         end
      end
      return r;
   endfunction

   function automatic logic [10:0] lock_window(input logic [1:0] code);
      logic [10:0] r;
      case (code)
         2'h0:    r = spdr_pkg::LOCK_WIN_128;
         2'h1:    r = spdr_pkg::LOCK_WIN_256;
         2'h2:    r = spdr_pkg::LOCK_WIN_512;
         default: r = spdr_pkg::LOCK_WIN_1024;
      endcase
      return r;
   endfunction

   // upper address bits outside the block's decode refuse the access
   function automatic logic in_range(input logic [11:0] a);
      return a[11:10] == 2'h0;
   endfunction

   function automatic logic [15:0] dir_interval(input logic        up,
                                                input logic [31:0] rate);
      logic [15:0] r;
      if (up) begin
         r = rate[spdr_pkg::RATE_UP_HI:spdr_pkg::RATE_UP_LO];
      end else begin
         r = rate[spdr_pkg::RATE_DN_HI:spdr_pkg::RATE_DN_LO];
      end
      return r;
   endfunction

   function automatic spdr_pkg::spdr_swp_e dir_state(input logic up);
      spdr_pkg::spdr_swp_e r;
      if (up) begin
         r = spdr_pkg::SWP_UP;
      end else begin
         r = spdr_pkg::SWP_DOWN;
      end
      return r;
   endfunction

   //------------------------------------------------------------
   // next state
   //------------------------------------------------------------
   logic [7:0]  idx;
   logic        acc;
   logic        wr;
   logic        hit;
   logic [spdr_pkg::IRQ_W-1:0] ev;
   logic [32:0] sum;
   logic [32:0] dif;
   logic        step;
   logic        swp_en;
   logic        cal_go;

   always_comb begin
      st_d   = st_q;
      ev     = '0;
      idx    = paddr[9:2];
      acc    = psel && penable && !st_q.pready;
      wr     = acc && pwrite && in_range(paddr);
      hit    = 1'b1;
      sum    = 33'h0_0000_0000;
      dif    = 33'h0_0000_0000;
      step   = 1'b0;
      swp_en = st_q.ctrl_two[spdr_pkg::SWP_EN_BIT];
      cal_go = 1'b0;

      //------------------------------------------------------------
      // apb slave: one wait state, answer in the cycle after access starts
      //------------------------------------------------------------
      st_d.pready  = acc;
      st_d.pslverr = 1'b0;
      if (acc) begin
         if (idx == spdr_pkg::IDX_CTRL_ONE) begin
            st_d.prdata = st_q.ctrl_one;
            st_d.prdata[spdr_pkg::PLL_LOCK_BIT] = st_q.locked;
            if (wr) begin
               st_d.ctrl_one = merge_bytes(st_q.ctrl_one, pwdata, pstrb);
            end
         end else if (idx == spdr_pkg::IDX_CTRL_TWO) begin
            st_d.prdata = st_q.ctrl_two;
            if (wr) begin
               st_d.ctrl_two = merge_bytes(st_q.ctrl_two, pwdata, pstrb);
            end
         end else if (idx == spdr_pkg::IDX_PLL_CTRL) begin
            st_d.prdata = st_q.pll_ctrl;
            if (wr) begin
               st_d.pll_ctrl = merge_bytes(st_q.pll_ctrl, pwdata, pstrb);
            end
         end else if (idx == spdr_pkg::IDX_CTRL_FOUR) begin
            st_d.prdata = st_q.ctrl_four;
            st_d.prdata[spdr_pkg::CAL_START_BIT] = st_q.cal_busy;
            if (wr) begin
               st_d.ctrl_four = merge_bytes(st_q.ctrl_four, pwdata, pstrb);
               st_d.ctrl_four[spdr_pkg::CAL_START_BIT] = 1'b0;
               if (pstrb[3] && pwdata[spdr_pkg::CAL_START_BIT]) begin
                  cal_go = 1'b1;
               end
            end
         end else if (idx == spdr_pkg::IDX_SWP_LOW) begin
            st_d.prdata = st_q.swp_low;
            if (wr) begin
               st_d.swp_low = merge_bytes(st_q.swp_low, pwdata, pstrb);
            end
         end else if (idx == spdr_pkg::IDX_SWP_HIGH) begin
            st_d.prdata = st_q.swp_high;
            if (wr) begin
               st_d.swp_high = merge_bytes(st_q.swp_high, pwdata, pstrb);
            end
         end else if (idx == spdr_pkg::IDX_SWP_RSTEP) begin
            st_d.prdata = st_q.swp_rstep;
            if (wr) begin
               st_d.swp_rstep = merge_bytes(st_q.swp_rstep, pwdata, pstrb);
            end
         end else if (idx == spdr_pkg::IDX_SWP_FSTEP) begin
            st_d.prdata = st_q.swp_fstep;
            if (wr) begin
               st_d.swp_fstep = merge_bytes(st_q.swp_fstep, pwdata, pstrb);
            end
         end else if (idx == spdr_pkg::IDX_SWP_RATE) begin
            st_d.prdata = st_q.swp_rate;
            if (wr) begin
               st_d.swp_rate = merge_bytes(st_q.swp_rate, pwdata, pstrb);
            end
         end else if (idx == spdr_pkg::IDX_IRQ_STAT) begin
            st_d.prdata = {{(32-spdr_pkg::IRQ_W){1'b0}}, st_q.irq_stat};
            if (wr && pstrb[0]) begin
               st_d.irq_stat = st_q.irq_stat & ~pwdata[spdr_pkg::IRQ_W-1:0];
            end
         end else if (idx == spdr_pkg::IDX_IRQ_MASK) begin
            st_d.prdata = {{(32-spdr_pkg::IRQ_W){1'b0}}, st_q.irq_mask};
            if (wr && pstrb[0]) begin
               st_d.irq_mask = pwdata[spdr_pkg::IRQ_W-1:0];
            end
         end else if (idx == spdr_pkg::IDX_SWP_VALUE) begin
            st_d.prdata = st_q.value;
         end else begin
            hit = 1'b0;
         end
         if (!hit || !in_range(paddr)) begin
            st_d.prdata  = spdr_pkg::ADDR_ERR_DATA;
            st_d.pslverr = 1'b1;
         end
      end

      //------------------------------------------------------------
      // lock qualification on reference clock ticks
      //------------------------------------------------------------
      if (!st_q.pll_ctrl[spdr_pkg::LOCK_DET_EN]) begin
         st_d.lock_cnt = '0;
         st_d.locked   = 1'b0;
      end else if (ref_clk_tick) begin
         if (!phase_err_in_window) begin
            st_d.lock_cnt = '0;
            st_d.locked   = 1'b0;
         end else if (st_q.lock_cnt >= lock_window(st_q.pll_ctrl[spdr_pkg::LOCK_WIN_HI:
                                                                 spdr_pkg::LOCK_WIN_LO]) - 11'h1) begin
            st_d.locked = 1'b1;
         end else begin
            st_d.lock_cnt = st_q.lock_cnt + 11'h1;
         end
      end
      if (st_d.locked && !st_q.locked) begin
         ev[spdr_pkg::IRQ_LOCK_BIT] = 1'b1;
      end
      if (!st_d.locked && st_q.locked) begin
         ev[spdr_pkg::IRQ_UNLOCK_BIT] = 1'b1;
      end

      //------------------------------------------------------------
      // converter calibration, counts only while its clock runs
      //------------------------------------------------------------
      if (cal_go) begin
         st_d.cal_busy = 1'b1;
         st_d.cal_cnt  = spdr_pkg::CAL_CYCLES;
      end else if (st_q.cal_busy && st_q.cal_clk_en) begin
         if (st_q.cal_cnt == 8'h01) begin
            st_d.cal_busy = 1'b0;
            ev[spdr_pkg::IRQ_CAL_BIT] = 1'b1;
         end
         st_d.cal_cnt = st_q.cal_cnt - 8'h01;
      end

      //------------------------------------------------------------
      // sweep generator
      //------------------------------------------------------------
      if (!swp_en) begin
         st_d.swp_state = spdr_pkg::SWP_IDLE;
         st_d.value     = st_q.swp_low;
         st_d.rate_cnt  = '0;
      end else begin
         case (st_q.swp_state)
            spdr_pkg::SWP_IDLE: begin
               st_d.value     = st_q.swp_low;
               st_d.swp_state = dir_state(sweep_dir_up);
               st_d.rate_cnt  = dir_interval(sweep_dir_up, st_q.swp_rate);
            end
            spdr_pkg::SWP_UP, spdr_pkg::SWP_DOWN: begin
               if (st_q.rate_cnt == 16'h0000) begin
                  step = 1'b1;
               end else begin
                  st_d.rate_cnt = st_q.rate_cnt - 16'h0001;
               end
               if (step) begin
                  if (st_q.swp_state == spdr_pkg::SWP_UP) begin
                     sum = {1'b0, st_q.value} + {1'b0, st_q.swp_rstep};
                     if (sum[32] || sum[31:0] >= st_q.swp_high) begin
                        st_d.value = st_q.swp_high;
                        if (st_q.value != st_q.swp_high) ev[spdr_pkg::IRQ_HIGH_BIT] = 1'b1;
                     end else begin
                        st_d.value = sum[31:0];
                     end
                  end else begin
                     dif = {1'b0, st_q.value} - {1'b0, st_q.swp_fstep};
                     if (dif[32] || dif[31:0] <= st_q.swp_low) begin
                        st_d.value = st_q.swp_low;
                        if (st_q.value != st_q.swp_low) ev[spdr_pkg::IRQ_LOW_BIT] = 1'b1;
                     end else begin
                        st_d.value = dif[31:0];
                     end
                  end
                  st_d.swp_state = dir_state(sweep_dir_up);
                  st_d.rate_cnt  = dir_interval(sweep_dir_up, st_q.swp_rate);
               end
            end
            default: begin
               st_d.swp_state = spdr_pkg::SWP_IDLE;
            end
         endcase
      end

      //------------------------------------------------------------
      // sticky events: a set in the clearing cycle wins
      //------------------------------------------------------------
      st_d.irq_stat = st_d.irq_stat | ev;

      //------------------------------------------------------------
      // registered outputs
      //------------------------------------------------------------
      st_d.swp_act    = st_d.swp_state != spdr_pkg::SWP_IDLE;
      st_d.cp_cur     = st_q.pll_ctrl[spdr_pkg::CP_CUR_HI:spdr_pkg::CP_CUR_LO];
      st_d.sync_en    = !st_q.ctrl_four[spdr_pkg::SYNC_PD_BIT];
      st_d.cal_clk_en = !st_q.ctrl_four[spdr_pkg::CAL_CLK_PD_BIT] &&
                        !st_q.ctrl_four[spdr_pkg::SYNC_PD_BIT];
      st_d.irq        = |(st_d.irq_stat & st_d.irq_mask);
   end

   //------------------------------------------------------------
   // registers
   //------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_q            <= '0;
         st_q.ctrl_four  <= spdr_pkg::CTRL_FOUR_RST;
         st_q.swp_state  <= spdr_pkg::SWP_IDLE;
         st_q.sync_en    <= 1'b1;
         st_q.cal_clk_en <= 1'b1;
      end else begin
         st_q <= st_d;
      end
   end

   //------------------------------------------------------------
   // outputs, each straight from a flop
   //------------------------------------------------------------
   assign prdata              = st_q.prdata;
   assign pready              = st_q.pready;
   assign pslverr             = st_q.pslverr;
   assign charge_pump_current = st_q.cp_cur;
   assign sync_out_enable     = st_q.sync_en;
   assign cal_clk_enable      = st_q.cal_clk_en;
   assign cal_busy            = st_q.cal_busy;
   assign sweep_value         = st_q.value;
   assign sweep_active        = st_q.swp_act;
   assign irq                 = st_q.irq;
endmodule
`default_nettype wire

// *** spdr_monitor.sv ***
// checker: apb timing and configuration output relations of spdr_top
`timescale 1ns/1ns
`default_nettype none
module spdr_monitor (
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0]  pstrb,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic [2:0]  charge_pump_current,
   input wire logic        sync_out_enable,
   input wire logic        cal_clk_enable,
   input wire logic        cal_busy,
   input wire logic [31:0] sweep_value,
   input wire logic        sweep_active
);
   logic        wr_hit;
   logic [31:0] cw4_q;
   logic [31:0] low_q;
   logic [31:0] high_q;
   logic [2:0]  pump_q;
   assign wr_hit = psel && penable && pready && pwrite;
   // shadow copies of the last completed writes
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cw4_q  <= 32'h0000_0000;
         low_q  <= 32'h0000_0000;
         high_q <= 32'h0000_0000;
         pump_q <= 3'h0;
      end else if (wr_hit) begin
         if (paddr == 12'h00C && pstrb[3]) cw4_q <= pwdata;
         if (paddr == 12'h010 && pstrb == 4'hF) low_q <= pwdata;
         if (paddr == 12'h014 && pstrb == 4'hF) high_q <= pwdata;
         if (paddr == 12'h008 && pstrb[0]) pump_q <= pwdata[5:3];
      end
   end
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_pump_follow: assert property (wr_hit && paddr == 12'h008 && pstrb[0] |-> ##2
      charge_pump_current == pump_q) else $error("pump current does not follow register");
   a_sync_power: assert property (wr_hit && paddr == 12'h00C && pstrb[3] |-> ##2
      sync_out_enable == !cw4_q[26]) else $error("sync enable wrong");
   a_calclk_gate: assert property (wr_hit && paddr == 12'h00C && pstrb[3] |-> ##2
      cal_clk_enable == !(cw4_q[25] || cw4_q[26])) else $error("cal clock enable wrong");
   a_cal_start: assert property (wr_hit && paddr == 12'h00C && pstrb[3] && pwdata[24]
      |-> ##[1:2] cal_busy) else $error("calibration not started");
   a_ready_pulse: assert property (pready |=> !pready) else $error("pready longer than one cycle");
   a_one_wait: assert property (psel && penable && !pready |=> pready) else $error("no ready");
   a_setup_quiet: assert property (psel && !penable |-> !pready) else $error("ready in setup");
   a_addr_refuse: assert property (pready && paddr[11:10] != 2'h0 |-> pslverr && prdata == 32'h0)
      else $error("out of range access not refused");
   a_sweep_clamp: assert property (sweep_active && $past(sweep_active)
      |-> sweep_value >= low_q && sweep_value <= high_q) else $error("sweep outside bounds");
endmodule
bind spdr_top spdr_monitor i_mon (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
   .prdata(prdata), .pready(pready), .pslverr(pslverr), .charge_pump_current(charge_pump_current),
   .sync_out_enable(sync_out_enable), .cal_clk_enable(cal_clk_enable), .cal_busy(cal_busy),
   .sweep_value(sweep_value), .sweep_active(sweep_active));
`default_nettype wire

// *** spdr_top_bench.sv ***
// testbench: register, lock, calibration, interrupt and sweep scenarios for spdr_top
`timescale 1ns/1ns
`default_nettype none
module spdr_top_bench;
   logic        pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, sweep_value, rd, lo, hi, st, ex, mdl [0:8];
   logic [3:0]  pstrb = 4'h0;
   logic [2:0]  charge_pump_current;
   logic        pready, pslverr, err, tick = 1'h0, in_win = 1'h1, dir_up = 1'h1;
   logic        sync_out_enable, cal_clk_enable, cal_busy, sweep_active, irq;
   int          num_errors = 0, n_compared = 0;
   always #25 pclk = ~pclk;
   spdr_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .ref_clk_tick(tick), .phase_err_in_window(in_win),
      .sweep_dir_up(dir_up), .charge_pump_current(charge_pump_current),
      .sync_out_enable(sync_out_enable), .cal_clk_enable(cal_clk_enable),
      .cal_busy(cal_busy), .sweep_value(sweep_value), .sweep_active(sweep_active), .irq(irq));
   // ----------------------------------------
   // shared tasks
   // ----------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      n_compared++;
      if (got !== exp) begin
         num_errors++;
         $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                      input logic [3:0] s);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'h1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      pstrb <= s;
      @(posedge pclk);
      penable <= 1'h1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'h1 && n < 20);
      rd = prdata;
      err = pslverr;
      if (n >= 20) chk(32'h0, 32'h1, "no pready");
      psel <= 1'h0;
      penable <= 1'h0;
   endtask
   task automatic ticks(input int n);
      repeat (n) begin
         @(posedge pclk);
         tick <= 1'h1;
         @(posedge pclk);
         tick <= 1'h0;
      end
   endtask
   task automatic sweep_run(input logic [31:0] step, input logic up, input int gap);
      logic [31:0] v;
      int n, k;
      k = 0;
      while (ex !== (up ? hi : lo) && k < 20) begin
         if (up) ex = (hi - ex < step) ? hi : ex + step;
         else ex = (ex - lo < step) ? lo : ex - step;
         v = sweep_value;
         n = 0;
         do begin
            @(posedge pclk);
            n++;
         end while (sweep_value === v && n < 100);
         chk(sweep_value, ex, "sweep value");
         if (k > 0) chk(32'(n), 32'(gap), "step interval");
         k++;
      end
      repeat (gap * 3) @(posedge pclk);
      chk(sweep_value, ex, "held at bound");
   endtask
   task automatic end_sim;
      $display("comparisons %0d, mismatches %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   initial begin
      #(60000 * 50);
      num_errors++;
      $display("unexpected at %0t: watchdog expired", $time);
      end_sim();
   end
   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      int c, len;
      rd = $urandom(35);
      repeat (10) @(posedge pclk);
      presetn <= 1'h1;
      apb(1'h0, 12'h0FC, 32'h0, 4'hF);
      chk({31'h0, err}, 32'h1, "unmapped refused");
      chk(rd, 32'h0, "unmapped data");
      apb(1'h1, 12'h410, 32'hFFFF_FFFF, 4'hF);
      chk({31'h0, err}, 32'h1, "out of range write refused");
      apb(1'h0, 12'h010, 32'h0, 4'hF);
      chk(rd, 32'h0, "refused write leaked");
      for (c = 4; c <= 8; c++) begin
         mdl[c] = $urandom;
         apb(1'h1, 12'(c * 4), mdl[c], 4'hF);
      end
      for (c = 4; c <= 8; c++) begin
         apb(1'h0, 12'(c * 4), 32'h0, 4'hF);
         chk(rd, mdl[c], "sweep register readback");
      end
      chk({31'h0, sweep_active}, 32'h0, "sweep idle while disabled");
      chk(sweep_value, mdl[4], "idle value is lower bound");
      for (c = 3; c >= 0; c--) begin
         apb(1'h1, 12'h00C, {5'h0, c[1:0], 25'h0}, 4'hF);
         repeat (2) @(posedge pclk);
         chk({31'h0, sync_out_enable}, {31'h0, !c[1]}, "sync enable");
         chk({31'h0, cal_clk_enable}, {31'h0, c == 0}, "cal clock");
      end
      for (c = 0; c < 4; c++) begin
         mdl[2] = (($urandom % 8) << 3) | 32'h4 | 32'(c);
         apb(1'h1, 12'h008, mdl[2], 4'h1);
         in_win <= 1'h0;
         ticks(1);
         in_win <= 1'h1;
         chk(32'(charge_pump_current), 32'(mdl[2][5:3]), "pump current");
         len = 128 << c;
         ticks(len - 1);
         apb(1'h0, 12'h000, 32'h0, 4'hF);
         chk(32'(rd[24]), 32'h0, "lock too early");
         ticks(1);
         repeat (2) @(posedge pclk);
         apb(1'h0, 12'h000, 32'h0, 4'hF);
         chk(32'(rd[24]), 32'h1, "lock at window end");
      end
      apb(1'h1, 12'h008, 32'h0, 4'h1);
      repeat (2) @(posedge pclk);
      apb(1'h0, 12'h000, 32'h0, 4'hF);
      chk(32'(rd[24]), 32'h0, "lock with detection off");
      apb(1'h0, 12'h080, 32'h0, 4'hF);
      chk(rd & 32'h3, 32'h3, "lock gained and lost status");
      apb(1'h1, 12'h080, 32'h1F, 4'h1);
      apb(1'h1, 12'h084, 32'h0, 4'h1);
      apb(1'h1, 12'h00C, 32'h0100_0000, 4'h8);
      c = 0;
      while (cal_busy !== 1'h1 && c < 10) begin
         @(posedge pclk);
         c++;
      end
      len = 0;
      while (cal_busy === 1'h1 && len < 200) begin
         @(posedge pclk);
         len++;
      end
      chk(32'(len), 32'(spdr_pkg::CAL_CYCLES), "calibration length");
      chk({31'h0, irq}, 32'h0, "masked irq");
      apb(1'h0, 12'h080, 32'h0, 4'hF);
      chk(rd & 32'h4, 32'h4, "calibration done status");
      apb(1'h1, 12'h084, 32'h4, 4'h1);
      repeat (2) @(posedge pclk);
      chk({31'h0, irq}, 32'h1, "unmasked irq");
      apb(1'h1, 12'h080, 32'h4, 4'h1);
      repeat (2) @(posedge pclk);
      chk({31'h0, irq}, 32'h0, "cleared irq");
      lo = 32'($urandom % 65536);
      st = 32'($urandom % 200 + 1);
      hi = lo + st * 3 + st / 2;
      apb(1'h1, 12'h010, lo, 4'hF);
      apb(1'h1, 12'h014, hi, 4'hF);
      apb(1'h1, 12'h018, st, 4'hF);
      apb(1'h1, 12'h01C, st + 7, 4'hF);
      apb(1'h1, 12'h020, 32'h0002_0003, 4'hF);
      ex = lo;
      apb(1'h1, 12'h004, 32'h0008_0000, 4'hF);
      sweep_run(st, 1'h1, 4);
      dir_up <= 1'h0;
      sweep_run(st + 7, 1'h0, 3);
      apb(1'h0, 12'h088, 32'h0, 4'hF);
      chk(rd, ex, "swept value readback");
      apb(1'h0, 12'h080, 32'h0, 4'hF);
      chk(rd & 32'h18, 32'h18, "bound reached status");
      apb(1'h1, 12'h004, 32'h0, 4'hF);
      repeat (3) @(posedge pclk);
      chk({31'h0, sweep_active}, 32'h0, "sweep stopped");
      end_sim();
   end
endmodule
`default_nettype wire
